// ---- design/cth_host.sv ----
// Host controller that drives a CAN transceiver through its transmit, receive and standby pins.
// Contract
// RULE1: Low is dominant, high is recessive.
// RULE2: Transceiver starts timeout on transmit falling edge.
// RULE3: Transceiver disables driver after timeout expires.
// RULE4: Transceiver clears timeout fault on recessive input.
// RULE5: Receiver keeps following bus during timeout.
// RULE6: Timeout supervision works only in normal mode.
// RULE7: Never hold dominant past the timeout period.
// RULE8: Over-temperature disables driver and transmit path.
// RULE9: Thermal fault clears below trip threshold.
// RULE10: Thermal fault keeps recessive bias and receive.
// RULE11: Wake event drives receive output low.
// RULE12: Receive output driven only with logic supply.
// RULE13: Standby select picks mode; low means normal.
// RULE14: Standby pulls bus lines weakly to ground.
// RULE15: Dominant overrides recessive; bus is wired-AND.
// RULE16: Standby keeps receive high until wake pattern.
// RULE17: In standby, falling receive edge returns normal.
// RULE18: Timeout counted in clock cycles, flags as inputs.
module cth_host
  import cth_pkg::*;
#(
  parameter int unsigned GUARD_CYCLES = CTH_GUARD_CYCLES_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic tx_bit,
  input wire logic sleep_req,
  input wire logic rxd,
  output logic txd,
  output logic standby_select,
  output logic rx_bit,
  output logic wake_seen,
  output logic bit_conflict,
  output logic guard_active,
  output logic in_standby
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam logic [CTH_CNT_W-1:0] GUARD_LIMIT = GUARD_CYCLES[CTH_CNT_W-1:0];
  localparam logic [CTH_CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CTH_CNT_W-1:0] CNT_ZERO = 16'h0000;

  cth_state_t state;
  cth_state_t next_state;
  cth_pins_t pins;
  cth_pins_t next_pins;
  logic [CTH_CNT_W-1:0] dom_cnt;
  logic [CTH_CNT_W-1:0] next_dom_cnt;
  logic guard;
  logic next_guard;
  logic guard_now;
  logic next_rx_bit;
  logic next_wake_seen;
  logic next_bit_conflict;
  logic rx_fall;

  assign txd = pins.txd;
  assign standby_select = pins.standby_select;
  assign guard_active = guard;
  assign in_standby = (state == CTH_ST_STANDBY);

  // ----------------------------------------
  // Mode control
  // ----------------------------------------
  // A falling receive edge seen in standby is the wake request from the bus.
  assign rx_fall = (rx_bit == CTH_LVL_RECESSIVE) && (rxd == CTH_LVL_DOMINANT);

  // Normal until asked to sleep; a wake holds normal until the request is dropped.
  always_comb begin
    next_state = state;
    unique case (state)
      CTH_ST_NORMAL: begin
        if (sleep_req) begin
          next_state = CTH_ST_STANDBY;
        end
      end
      CTH_ST_STANDBY: begin
        if (rx_fall) begin
          next_state = CTH_ST_AWAKE; // see RULE17
        end else if (!sleep_req) begin
          next_state = CTH_ST_NORMAL;
        end
      end
      CTH_ST_AWAKE: begin
        if (!sleep_req) begin
          next_state = CTH_ST_NORMAL;
        end
      end
      default: begin
        next_state = CTH_ST_NORMAL;
      end
    endcase
  end

  // Registers the mode group; reset starts in normal mode.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= CTH_ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Transmit path with dominant guard
  // ----------------------------------------
  // The guard cuts a dominant run short before the transceiver timeout could fire.
  always_comb begin
    guard_now = guard || ((pins.txd == CTH_LVL_DOMINANT) && (dom_cnt >= GUARD_LIMIT)); // see RULE7
    next_guard = guard_now && (tx_bit == CTH_LVL_DOMINANT);
    next_pins.standby_select = (next_state == CTH_ST_STANDBY) ? CTH_SEL_STANDBY : CTH_SEL_NORMAL; // see RULE13
    if ((next_state == CTH_ST_STANDBY) || guard_now) begin
      next_pins.txd = CTH_LVL_RECESSIVE;
    end else begin
      next_pins.txd = tx_bit; // see RULE1
    end
    next_dom_cnt = (next_pins.txd == CTH_LVL_DOMINANT) ? (dom_cnt + CNT_ONE) : CNT_ZERO;
  end

  // Registers the transmit group; reset leaves the pins in normal mode, recessive.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins <= '{txd: CTH_LVL_RECESSIVE, standby_select: CTH_SEL_NORMAL};
      dom_cnt <= CNT_ZERO;
      guard <= 1'h0;
    end else begin
      pins <= next_pins;
      dom_cnt <= next_dom_cnt;
      guard <= next_guard;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  // Sending recessive while the bus reads dominant means another node won the bus.
  always_comb begin
    next_rx_bit = rxd;
    next_wake_seen = (state == CTH_ST_STANDBY) && rx_fall;
    next_bit_conflict = (state != CTH_ST_STANDBY) && (pins.txd == CTH_LVL_RECESSIVE) &&
                        (rxd == CTH_LVL_DOMINANT); // see RULE15
  end

  // Registers the receive group; reset shows a recessive, quiet receiver.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_bit <= CTH_LVL_RECESSIVE;
      wake_seen <= 1'h0;
      bit_conflict <= 1'h0;
    end else begin
      rx_bit <= next_rx_bit;
      wake_seen <= next_wake_seen;
      bit_conflict <= next_bit_conflict;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_standby_fall;
    (state == CTH_ST_STANDBY) && rx_fall;
  endsequence

  sequence s_woken;
    (standby_select == CTH_SEL_NORMAL) && (state == CTH_ST_AWAKE) && wake_seen;
  endsequence

  property p_dom_map;
    @(posedge ref_clk) disable iff (srst)
      (txd == CTH_LVL_DOMINANT) |-> ($past(tx_bit) == CTH_LVL_DOMINANT) && !in_standby;
  endproperty
  a_dom_map: assert property (p_dom_map) else $error("dominant sent without dominant request"); // see RULE1

  property p_guard_bound;
    @(posedge ref_clk) disable iff (srst)
      dom_cnt <= GUARD_LIMIT + CNT_ONE;
  endproperty
  a_guard_bound: assert property (p_guard_bound) else $error("dominant run too long"); // see RULE7

  property p_guard_release;
    @(posedge ref_clk) disable iff (srst)
      guard && (tx_bit == CTH_LVL_RECESSIVE) |=> !guard;
  endproperty
  a_guard_release: assert property (p_guard_release) else $error("guard not released"); // see RULE7

  property p_stb_level;
    @(posedge ref_clk) disable iff (srst)
      (standby_select == CTH_SEL_STANDBY) == in_standby;
  endproperty
  a_stb_level: assert property (p_stb_level) else $error("standby pin disagrees with mode"); // see RULE13

  property p_sleep_enter;
    @(posedge ref_clk) disable iff (srst)
      (state == CTH_ST_NORMAL) && sleep_req |=> (standby_select == CTH_SEL_STANDBY);
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("standby not entered"); // see RULE13

  property p_wake_return;
    @(posedge ref_clk) disable iff (srst)
      s_standby_fall |=> s_woken;
  endproperty
  a_wake_return: assert property (p_wake_return) else $error("wake edge did not return to normal"); // see RULE17

  property p_conflict;
    @(posedge ref_clk) disable iff (srst)
      !in_standby && (txd == CTH_LVL_RECESSIVE) && (rxd == CTH_LVL_DOMINANT) |=> bit_conflict;
  endproperty
  a_conflict: assert property (p_conflict) else $error("lost bit not flagged"); // see RULE15

  property p_standby_quiet;
    @(posedge ref_clk) disable iff (srst)
      in_standby |-> (txd == CTH_LVL_RECESSIVE) ##1 !bit_conflict;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("activity in standby"); // see RULE13

  property p_guard_cut;
    @(posedge ref_clk) disable iff (srst)
      (txd == CTH_LVL_DOMINANT) && (dom_cnt >= GUARD_LIMIT) |=> (txd == CTH_LVL_RECESSIVE);
  endproperty
  a_guard_cut: assert property (p_guard_cut) else $error("dominant run not cut at the limit"); // see RULE7

endmodule

// ---- design/cth_pkg.sv ----
// Constants, state encoding and pin bundle for the transceiver host controller.
package cth_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CTH_CLK_PERIOD_NS = 40;
  localparam int unsigned CTH_DOMINANT_TIMEOUT_PERIOD_NS = 1200000;
  localparam int unsigned CTH_DOMINANT_TIMEOUT_CYCLES =
    CTH_DOMINANT_TIMEOUT_PERIOD_NS / CTH_CLK_PERIOD_NS;
  localparam int unsigned CTH_GUARD_MARGIN_NS = 1000;
  localparam int unsigned CTH_GUARD_MARGIN_CYCLES =
    (CTH_GUARD_MARGIN_NS + CTH_CLK_PERIOD_NS - 1) / CTH_CLK_PERIOD_NS;
  localparam int unsigned CTH_GUARD_CYCLES_DEFAULT =
    CTH_DOMINANT_TIMEOUT_CYCLES - CTH_GUARD_MARGIN_CYCLES;
  localparam int unsigned CTH_CNT_W = 16;

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  localparam logic CTH_LVL_DOMINANT = 1'h0;
  localparam logic CTH_LVL_RECESSIVE = 1'h1;
  localparam logic CTH_SEL_NORMAL = 1'h0;
  localparam logic CTH_SEL_STANDBY = 1'h1;

  // ----------------------------------------
  // Mode states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CTH_ST_NORMAL = 3'h1,
    CTH_ST_STANDBY = 3'h2,
    CTH_ST_AWAKE = 3'h4
  } cth_state_t;

  // Pins driven toward the transceiver.
  typedef struct packed {
    logic txd;
    logic standby_select;
  } cth_pins_t;

endpackage

// ---- dv/cth_host_tb.sv ----
// Self-checking bench for the transceiver host controller.
module cth_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cth_pkg::*;
  localparam int G = 8;
  logic ref_clk = 0, srst = 1, tx_bit = 1, sleep_req = 0, other_dom = 0, wake = 0, hot = 0;
  logic rxd, txd, standby_select, rx_bit, wake_seen, bit_conflict, guard_active, in_standby;
  int n_fail = 0, check_count = 0, cyc = 0;

  always #20 ref_clk = ~ref_clk;

  cth_host #(.GUARD_CYCLES(G)) dut_u (.ref_clk(ref_clk), .srst(srst), .tx_bit(tx_bit),
    .sleep_req(sleep_req), .rxd(rxd), .txd(txd), .standby_select(standby_select), .rx_bit(rx_bit),
    .wake_seen(wake_seen), .bit_conflict(bit_conflict), .guard_active(guard_active), .in_standby(in_standby));
  cth_xcvr_model #(.TIMEOUT_CYC(G + 4)) xcvr_u (.ref_clk(ref_clk), .srst(srst), .txd(txd),
    .standby_select(standby_select), .other_dom(other_dom), .hot(hot), .wake(wake), .rxd(rxd));

  task automatic chk(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick;
    @(posedge ref_clk);
    #1;
  endtask

  task wrap_up;
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Dominant bit goes out one cycle late and comes back through the receiver.
  task t_tx;
    tx_bit = 0;
    tick;
    chk("txd", CTH_LVL_DOMINANT, txd);
    tick;
    chk("rx_bit", CTH_LVL_DOMINANT, rx_bit);
    tx_bit = 1;
    tick;
    chk("txd", CTH_LVL_RECESSIVE, txd);
  endtask

  // Held dominant is cut off after G cycles and released by a recessive bit.
  task t_guard;
    tx_bit = 0;
    repeat (G) begin
      tick;
      chk("txd", 1'h0, txd);
    end
    tick;
    chk("txd", 1'h1, txd);
    chk("guard_active", 1'h1, guard_active);
    tx_bit = 1;
    tick;
    tick;
    chk("guard_active", 1'h0, guard_active);
    tx_bit = 0;
    tick;
    chk("txd", 1'h0, txd);
    tx_bit = 1;
    tick;
  endtask

  // Another node wins arbitration while this one sends recessive.
  task t_conflict;
    other_dom = 1;
    tick;
    tick;
    chk("bit_conflict", 1'h1, bit_conflict);
    chk("rx_bit", 1'h0, rx_bit);
    other_dom = 0;
    tick;
    tick;
    chk("bit_conflict", 1'h0, bit_conflict);
  endtask

  // Overheating cuts the driver but the receiver still follows the bus.
  task t_thermal;
    hot = 1;
    tx_bit = 0;
    tick;
    tick;
    chk("txd", CTH_LVL_DOMINANT, txd);
    chk("rx_bit", CTH_LVL_RECESSIVE, rx_bit);
    other_dom = 1;
    tick;
    chk("rx_bit", CTH_LVL_DOMINANT, rx_bit);
    other_dom = 0;
    hot = 0;
    tick;
    chk("rx_bit", CTH_LVL_DOMINANT, rx_bit);
    tx_bit = 1;
    tick;
    tick;
    chk("rx_bit", CTH_LVL_RECESSIVE, rx_bit);
  endtask

  // Standby blocks transmit, a falling receive edge wakes, a dropped request also leaves.
  task t_standby;
    sleep_req = 1;
    tick;
    chk("standby_select", CTH_SEL_STANDBY, standby_select);
    chk("in_standby", 1'h1, in_standby);
    tx_bit = 0;
    other_dom = 1;
    tick;
    tick;
    chk("txd", 1'h1, txd);
    chk("bit_conflict", 1'h0, bit_conflict);
    wake = 1;
    tick;
    chk("standby_select", CTH_SEL_NORMAL, standby_select);
    chk("wake_seen", 1'h1, wake_seen);
    wake = 0;
    other_dom = 0;
    tx_bit = 1;
    tick;
    chk("wake_seen", 1'h0, wake_seen);
    chk("standby_select", 1'h0, standby_select);
    sleep_req = 0;
    tick;
    sleep_req = 1;
    tick;
    tick;
    chk("standby_select", 1'h1, standby_select);
    sleep_req = 0;
    tick;
    tick;
    chk("standby_select", 1'h0, standby_select);
  endtask

  // Cuts a hung run short.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      wrap_up;
    end
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    srst = 0;
    chk("txd", 1'h1, txd);
    chk("guard_active", 1'h0, guard_active);
    t_tx;
    t_guard;
    t_conflict;
    t_thermal;
    t_standby;
    wrap_up;
  end
endmodule

// ---- dv/cth_xcvr_model.sv ----
// Behavioural transceiver model that answers the host controller on its pins.
module cth_xcvr_model #(
  parameter int TIMEOUT_CYC = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic txd,
  input wire logic standby_select,
  input wire logic other_dom,
  input wire logic hot,
  input wire logic wake,
  output logic rxd
);
  logic [15:0] tmo_cnt;
  logic tmo_fault;
  logic bus_dom;

  // Times a dominant run on the transmit pin; the fault drops once the pin is recessive.
  always_ff @(posedge ref_clk) begin
    if (srst || txd || standby_select) begin
      tmo_cnt <= 16'h0;
      tmo_fault <= 1'h0;
    end else if (tmo_cnt == TIMEOUT_CYC[15:0]) begin
      tmo_fault <= 1'h1;
    end else begin
      tmo_cnt <= tmo_cnt + 16'h1;
    end
  end

  // Wired-AND bus: this driver or another node pulls dominant; standby leaves the driver off.
  assign bus_dom = (!txd && !standby_select && !tmo_fault && !hot) || other_dom;
  // The receiver keeps following the bus in faults; standby shows recessive until a wake.
  // The logic supply is taken as always present, so the receive pin is always driven.
  assign rxd = standby_select ? !wake : !bus_dom;
endmodule
